// [src/irq_pkg.sv]
package irq_pkg;

  // source count and field widths
  localparam int unsigned SRC_NUM   = 5;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned LVL_W     = 2;
  localparam int unsigned DEPTH_W   = 3;
  localparam int unsigned STACK_NUM = 8;

  // priority bit codes as held in condition_code_reg
  localparam logic [1:0] CC_LVL0  = 2'b10;
  localparam logic [1:0] CC_LVL1  = 2'b01;
  localparam logic [1:0] CC_LVL2  = 2'b00;
  localparam logic [1:0] CC_LVL3  = 2'b11;
  localparam logic [1:0] CC_RESET = 2'b11;
  localparam logic [1:0] CC_HALT  = 2'b10;

  // sources able to leave halt (external ones included); one bit a source
  localparam logic [4:0] HALT_WAKE_MASK = 5'h03;

  localparam logic [2:0] DEPTH_RESET = 3'h0;
  localparam logic [2:0] IDX_RESET   = 3'h0;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_HALT = 2'b10
  } pwr_state_t;

  // condition-code priority bits to a plain ordered level 0..3
  function automatic logic [1:0] cc_to_lvl(input logic [1:0] cc);
    unique case (cc)
      CC_LVL0: cc_to_lvl = 2'd0;
      CC_LVL1: cc_to_lvl = 2'd1;
      CC_LVL2: cc_to_lvl = 2'd2;
      CC_LVL3: cc_to_lvl = 2'd3;
    endcase
  endfunction : cc_to_lvl

  // plain ordered level back to condition-code priority bits
  function automatic logic [1:0] lvl_to_cc(input logic [1:0] lvl);
    unique case (lvl)
      2'd0: lvl_to_cc = CC_LVL0;
      2'd1: lvl_to_cc = CC_LVL1;
      2'd2: lvl_to_cc = CC_LVL2;
      2'd3: lvl_to_cc = CC_LVL3;
    endcase
  endfunction : lvl_to_cc

endpackage : irq_pkg

// [src/irq_arbiter.sv]
`timescale 1ns/1ps

module irq_arbiter (
  input  wire logic [4:0] req,
  input  wire logic [9:0] sw_cc,
  input  wire logic [1:0] run_lvl,
  output logic            found,
  output logic [2:0]      idx,
  output logic [1:0]      lvl
);
  import irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // walk from the lowest chain position up; >= lets the higher one win
  always_comb begin
    logic [1:0] cand;
    cand  = 2'd0;
    found = 1'b0;
    idx   = IDX_RESET;
    lvl   = 2'd0;
    for (int i = SRC_NUM - 1; i >= 0; i--) begin
      cand = cc_to_lvl(sw_cc[2*i +: 2]);
      if (req[i] && cand > run_lvl && (!found || cand >= lvl)) begin
        found = 1'b1;
        idx   = 3'(i);
        lvl   = cand;
      end
    end
  end

endmodule : irq_arbiter

// [src/irq_priority_wakeup.sv]
`timescale 1ns/1ps

// Functional notes
// - any eligible request leaves wait
// - halt left only by halt-capable sources
// - first service after halt is halt-capable
// - deferred non-halt source served after first
// - concurrent mode never pre-empts running routine
// - nested mode pre-empts on higher level
// - chain: main, it4, it3, it2, it1, it0
// - each source carries software priority level
// - stack overflow goes silently undetected
// - halt entry forces priority bits to 10b
// - push bits, set routine level, pop restores
module irq_priority_wakeup (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [4:0] irq_req,
  input  wire logic [9:0] irq_sw_prio,
  input  wire logic       nested_mode,
  input  wire logic       cpu_wait_enter,
  input  wire logic       cpu_halt_enter,
  input  wire logic       irq_take,
  input  wire logic       irq_return,
  input  wire logic       cc_wr,
  input  wire logic [1:0] cc_wr_data,
  output logic            irq_valid,
  output logic [2:0]      irq_vector,
  output logic [1:0]      condition_code_reg,
  output logic [2:0]      nest_depth,
  output logic            cpu_wake,
  output irq_pkg::pwr_state_t pwr_state
);
  import irq_pkg::*;

  pwr_state_t  pwr_reg;
  logic [1:0]  cc_reg;
  logic [2:0]  depth_reg;
  logic [1:0]  stack_mem [STACK_NUM];
  logic        halt_first_reg;
  logic [2:0]  first_depth_reg;
  logic        sel_valid_reg;
  logic [2:0]  sel_idx_reg;
  logic [1:0]  sel_lvl_reg;
  logic        wake_reg;
  logic [4:0]  arb_req;
  logic        arb_found;
  logic [2:0]  arb_idx;
  logic [1:0]  arb_lvl;
  logic        take_fire;
  logic        ret_fire;
  logic [1:0]  stack_top;
  logic        halt_entry;

  ////////////////////////////////////////////////////////////////////////
  // candidate filter: halted or first service after halt, halt set only
  always_comb begin
    if (pwr_reg == PWR_HALT || halt_first_reg)
      arb_req = irq_req & HALT_WAKE_MASK;
    else
      arb_req = irq_req;
  end

  irq_arbiter u_arb (
    .req     (arb_req),
    .sw_cc   (irq_sw_prio),
    .run_lvl (cc_to_lvl(cc_reg)),
    .found   (arb_found),
    .idx     (arb_idx),
    .lvl     (arb_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // handshake: no offer below top level in concurrent mode
  assign irq_valid = sel_valid_reg && pwr_reg == PWR_RUN
                     && (nested_mode
                         || depth_reg == DEPTH_RESET);
  assign take_fire  = irq_take && irq_valid;
  assign ret_fire   = irq_return && depth_reg != DEPTH_RESET;
  assign stack_top  = stack_mem[depth_reg - 3'd1];
  assign halt_entry = cpu_halt_enter && pwr_reg == PWR_RUN;

  ////////////////////////////////////////////////////////////////////////
  // registered selection, dropped on a take, a return or a software write of the priority bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_valid_reg <= 1'b0;
      sel_idx_reg   <= IDX_RESET;
      sel_lvl_reg   <= 2'd0;
    end else begin
      sel_valid_reg <= arb_found && !take_fire && !ret_fire && !cc_wr;
      sel_idx_reg   <= arb_idx;
      sel_lvl_reg   <= arb_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state and wake pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_reg  <= PWR_RUN;
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= 1'b0;
      unique case (pwr_reg)
        PWR_RUN: begin
          if (cpu_halt_enter)
            pwr_reg <= PWR_HALT;
          else if (cpu_wait_enter)
            pwr_reg <= PWR_WAIT;
        end
        PWR_WAIT: begin
          if (arb_found) begin
            pwr_reg  <= PWR_RUN;
            wake_reg <= 1'b1;
          end
        end
        PWR_HALT: begin
          if (arb_found) begin
            pwr_reg  <= PWR_RUN;
            wake_reg <= 1'b1;
          end
        end
        default: pwr_reg <= PWR_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // halt-exit restriction held until the first routine returns
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      halt_first_reg  <= 1'b0;
      first_depth_reg <= DEPTH_RESET;
    end else if (pwr_reg == PWR_HALT && arb_found) begin
      halt_first_reg  <= 1'b1;
      first_depth_reg <= depth_reg;
    end else if (ret_fire && depth_reg == first_depth_reg + 3'd1) begin
      halt_first_reg  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority bits: halt force, service entry, return, software write
  always_ff @(posedge clock) begin
    if (sys_rst)
      cc_reg <= CC_RESET;
    else if (halt_entry)
      cc_reg <= CC_HALT;
    else if (take_fire)
      cc_reg <= lvl_to_cc(sel_lvl_reg);
    else if (ret_fire)
      cc_reg <= stack_top;
    else if (cc_wr)
      cc_reg <= cc_wr_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // saved priority stack; pointer wraps with no overflow flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      depth_reg <= DEPTH_RESET;
    end else if (take_fire) begin
      stack_mem[depth_reg] <= cc_reg;
      depth_reg            <= depth_reg + 3'd1;
    end else if (ret_fire) begin
      depth_reg <= depth_reg - 3'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_vector         = sel_idx_reg;
  assign condition_code_reg = cc_reg;
  assign nest_depth         = depth_reg;
  assign cpu_wake           = wake_reg;
  assign pwr_state          = pwr_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence seq_wait_hit;
    pwr_reg == PWR_WAIT && arb_found;
  endsequence

  sequence seq_woken;
    pwr_reg == PWR_RUN && wake_reg;
  endsequence

  sequence seq_taken;
    take_fire ##1 depth_reg == $past(depth_reg) + 3'd1;
  endsequence

  AST_WAIT_EXIT: assert property (
    seq_wait_hit |=> seq_woken)
    else $error("wait not left on eligible request");

  AST_HALT_HOLD: assert property (
    pwr_reg == PWR_HALT && (irq_req & HALT_WAKE_MASK) == 5'h00
    |=> pwr_reg == PWR_HALT)
    else $error("halt left without halt-capable request");

  AST_HALT_FIRST: assert property (
    take_fire && halt_first_reg |-> HALT_WAKE_MASK[irq_vector])
    else $error("non halt-capable source served first");

  AST_DEFER_END: assert property (
    $fell(halt_first_reg) |-> $past(ret_fire))
    else $error("halt restriction ended without a return");

  AST_NO_PREEMPT: assert property (
    !nested_mode && depth_reg != DEPTH_RESET |-> !irq_valid)
    else $error("pre-emption offered in concurrent mode");

  AST_LEVEL_ABOVE: assert property (
    irq_valid |-> sel_lvl_reg > cc_to_lvl(cc_reg))
    else $error("offered request not above running level");

  AST_HALT_CC: assert property (
    halt_entry |=> cc_reg == CC_HALT && pwr_reg == PWR_HALT)
    else $error("priority bits not forced on halt entry");

  AST_ENTRY_LVL: assert property (
    seq_taken |-> cc_reg == lvl_to_cc($past(sel_lvl_reg)))
    else $error("routine level not loaded on entry");

  AST_RETURN_POP: assert property (
    ret_fire |=> cc_reg == $past(stack_top))
    else $error("priority bits not restored on return");

endmodule : irq_priority_wakeup

// [sim/cpu_model.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// cpu side: takes one offered request a cycle after it is armed
module cpu_model (
  input  wire logic clock,
  input  wire logic take_en,
  input  wire logic irq_valid,
  output logic      irq_take
);
  initial irq_take = 1'b0;

  // one-cycle take, never two in a row, so each offer is taken once
  always @(negedge clock) begin
    irq_take <= take_en && (irq_valid === 1'b1) && !irq_take;
  end
endmodule : cpu_model

// [sim/interrupt_priority_wakeup_tb_top.sv]
`timescale 1ns/1ps

module interrupt_priority_wakeup_tb_top;
  import irq_pkg::*;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [4:0] irq_req = 5'h00;
  logic [9:0] irq_sw_prio = 10'h155;
  logic       nested_mode = 1'b0;
  logic       cpu_wait_enter = 1'b0;
  logic       cpu_halt_enter = 1'b0;
  logic       irq_return = 1'b0;
  logic       cc_wr = 1'b0;
  logic       take_en = 1'b0;
  logic [1:0] cc_wr_data = 2'h2;
  logic       irq_take, irq_valid, cpu_wake;
  logic [2:0] irq_vector, nest_depth;
  logic [1:0] condition_code_reg;
  pwr_state_t pwr_state;
  int         err_count = 0;
  int         samples_checked = 0;

  always #20 clock = ~clock;

  irq_priority_wakeup irq_priority_wakeup_i (
    .clock(clock), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_sw_prio(irq_sw_prio), .nested_mode(nested_mode),
    .cpu_wait_enter(cpu_wait_enter), .cpu_halt_enter(cpu_halt_enter),
    .irq_take(irq_take), .irq_return(irq_return), .cc_wr(cc_wr),
    .cc_wr_data(cc_wr_data), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .condition_code_reg(condition_code_reg),
    .nest_depth(nest_depth), .cpu_wake(cpu_wake), .pwr_state(pwr_state));

  cpu_model cpu_model_i (.clock(clock), .take_en(take_en),
    .irq_valid(irq_valid), .irq_take(irq_take));

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  // bounded wait for an offer (run=0) or for the run state (run=1)
  task automatic wait_for(input bit run);
    int k = 0;
    while (!(run ? pwr_state === PWR_RUN : irq_valid === 1'b1)) begin
      if (++k > 30) begin
        chk("wait bound", 3'h1, 3'h0);
        report_and_stop();
      end
      step(1);
    end
  endtask : wait_for

  // reset, check reset outputs, open priority bits to level 0
  task automatic init(input logic [9:0] p);
    sys_rst = 1'b1;
    irq_req = 5'h00;
    nested_mode = 1'b0;
    irq_sw_prio = p;
    step(8);
    sys_rst = 1'b0;
    chk("reset cc", {1'b0, CC_RESET}, {1'b0, condition_code_reg});
    chk("reset depth", 3'h0, nest_depth);
    chk("reset pwr", 3'h0, {1'b0, pwr_state});
    chk("reset valid", 3'h0, {2'h0, irq_valid});
    cc_wr_data = CC_LVL0;
    pulse(cc_wr);
    step(1);
  endtask : init

  task automatic take_it(input logic [2:0] v);
    wait_for(1'b0);
    chk("vector", v, irq_vector);
    // non-blocking so the cpu model never races this edge's update
    take_en <= 1'b1;
    step(2);
    take_en <= 1'b0;
  endtask : take_it

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_chain;
    init(10'h155);
    for (int i = 0; i < 5; i++) begin
      irq_req = 5'h1f << i;
      step(2);
      chk("chain", i[2:0], irq_vector);
    end
    $display("test chain done");
  endtask : t_chain

  task automatic t_conc;
    init(10'h055);
    irq_req = 5'h01;
    take_it(3'h0);
    chk("entry cc", {1'b0, CC_LVL1}, {1'b0, condition_code_reg});
    chk("entry depth", 3'h1, nest_depth);
    irq_req = 5'h11;
    step(4);
    chk("no preempt", 3'h0, {2'h0, irq_valid});
    pulse(irq_return);
    chk("pop cc", {1'b0, CC_LVL0}, {1'b0, condition_code_reg});
    chk("pop depth", 3'h0, nest_depth);
    take_it(3'h4);
    $display("test concurrent done");
  endtask : t_conc

  task automatic t_nest;
    init(10'h055);
    nested_mode = 1'b1;
    irq_req = 5'h01;
    take_it(3'h0);
    irq_req = 5'h11;
    take_it(3'h4);
    chk("nest cc", {1'b0, CC_LVL2}, {1'b0, condition_code_reg});
    chk("nest depth", 3'h2, nest_depth);
    pulse(irq_return);
    chk("nest pop", {1'b0, CC_LVL1}, {1'b0, condition_code_reg});
    $display("test nested done");
  endtask : t_nest

  task automatic t_wait;
    init(10'h155);
    pulse(cpu_wait_enter);
    chk("wait pwr", 3'h1, {1'b0, pwr_state});
    irq_req = 5'h10;
    wait_for(1'b1);
    chk("wait wake", 3'h1, {2'h0, cpu_wake});
    $display("test wait done");
  endtask : t_wait

  task automatic t_halt;
    init(10'h055);
    cc_wr_data = CC_LVL1;
    pulse(cc_wr);
    pulse(cpu_halt_enter);
    chk("halt pwr", 3'h2, {1'b0, pwr_state});
    chk("halt cc", {1'b0, CC_HALT}, {1'b0, condition_code_reg});
    irq_req = 5'h10;
    step(5);
    chk("halt hold", 3'h2, {1'b0, pwr_state});
    irq_req = 5'h12;
    wait_for(1'b1);
    chk("halt wake", 3'h1, {2'h0, cpu_wake});
    take_it(3'h1);
    pulse(irq_return);
    take_it(3'h4);
    $display("test halt done");
  endtask : t_halt

  initial begin
    t_chain();
    t_conc();
    t_nest();
    t_wait();
    t_halt();
    report_and_stop();
  end
endmodule : interrupt_priority_wakeup_tb_top
